// >>> verilog/toa_base_station.sv
// base station end: receive window supervision and toa reporting
//
// Function
// - hold window start and end per bearer
// - data frame outside window yields timing adjustment report
// - frames between window end and latest still processed
// - controller probes with sync frame carrying cfn
// - always answer sync probe with toa
// - both negative: most negative advances
// - mixed signs: negative one advances
// - both positive: smaller one delays
`timescale 1ns/1ps
`default_nettype none
module toa_base_station
    import toa_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST_N,
    toa_link_if.bs LINK,
    input wire logic CFG_LOAD,
    input wire logic [TIME_W-1:0] CFG_TOAWS,
    input wire logic [TIME_W-1:0] CFG_TOAWE,
    input wire logic [TIME_W-1:0] ARRIVAL_TIME,
    output logic DATA_ACCEPT,
    output logic DATA_LATE,
    output logic DATA_DROP,
    output logic [TIME_W-1:0] WIN_START,
    output logic [TIME_W-1:0] WIN_END
);
    // arrival_time counts ticks remaining to the latest arrival point;
    // zero marks latest arrival, larger is earlier
    mon_state_t state_ff;
    logic [TIME_W-1:0] toaws_ff;
    logic [TIME_W-1:0] toawe_ff;
    logic [TIME_W-1:0] arr_ff;
    dl_kind_t kind_ff;
    logic [CFN_W-1:0] cfn_ff;
    logic signed [TOA_W-1:0] toa_ff;
    ul_kind_t ul_kind_ff;
    logic [CFN_W-1:0] ul_cfn_ff;
    logic accept_ff;
    logic late_ff;
    logic drop_ff;
    logic signed [TOA_W:0] toa_wide;
    logic outside;
    logic after_end;
    logic beyond_latest;
    logic eval_data;
    logic take;
    logic cfg_take;

    // clamp to the report width so a far-off frame never flips sign
    function automatic logic signed [TOA_W-1:0] sat_toa(input logic signed [TOA_W:0] v);
        if (v[TOA_W] != v[TOA_W-1]) begin
            return {v[TOA_W], {(TOA_W-1){~v[TOA_W]}}};
        end
        return v[TOA_W-1:0];
    endfunction

    // ready is combinational, so an offered frame is taken on the first idle edge
    assign take = state_ff == ST_IDLE && LINK.dl_valid;
    // new window lands only between frames: one frame, one window
    assign cfg_take = CFG_LOAD && state_ff == ST_IDLE;
    assign eval_data = state_ff == ST_EVAL && kind_ff == FR_DATA;

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            toaws_ff <= TOAWS_RST;
        end else if (cfg_take) begin
            toaws_ff <= CFG_TOAWS;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            toawe_ff <= TOAWE_RST;
        end else if (cfg_take) begin
            toawe_ff <= CFG_TOAWE;
        end
    end

    // toa relative to window end: arrival distance minus end margin
    assign toa_wide = $signed({1'b0, arr_ff}) - $signed({1'b0, toawe_ff});
    assign after_end = toa_wide < 0;
    // a frame right at the latest point leaves no time to process it
    assign beyond_latest = (arr_ff == '0) && (toawe_ff != '0);
    // window start is measured from window end
    assign outside = after_end || (toa_wide > $signed({1'b0, toaws_ff}));

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_ff <= ST_IDLE;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (LINK.dl_valid) begin
                        state_ff <= ST_EVAL;
                    end
                end
                ST_EVAL: begin
                    if (kind_ff == FR_SYNC || outside) begin
                        state_ff <= ST_SEND;
                    end else begin
                        state_ff <= ST_IDLE;
                    end
                end
                ST_SEND: begin
                    if (LINK.ul_ready) begin
                        state_ff <= ST_IDLE;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // arrival and frame fields are latched as the frame is taken
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            arr_ff <= '0;
        end else if (take) begin
            arr_ff <= ARRIVAL_TIME;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            kind_ff <= FR_DATA;
        end else if (take) begin
            kind_ff <= LINK.dl_kind;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cfn_ff <= '0;
        end else if (take) begin
            cfn_ff <= LINK.dl_cfn;
        end
    end

    // report fields are latched in evaluation and stand through the send state
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            toa_ff <= '0;
        end else if (state_ff == ST_EVAL) begin
            toa_ff <= sat_toa(toa_wide);
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ul_cfn_ff <= '0;
        end else if (state_ff == ST_EVAL) begin
            ul_cfn_ff <= cfn_ff;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ul_kind_ff <= UP_TIMING_ADJ;
        end else if (state_ff == ST_EVAL) begin
            ul_kind_ff <= (kind_ff == FR_SYNC) ? UP_SYNC_REPLY : UP_TIMING_ADJ;
        end
    end

    // data verdict pulses for one cycle, the cycle after evaluation
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            accept_ff <= 1'b0;
        end else begin
            accept_ff <= eval_data && !beyond_latest;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            late_ff <= 1'b0;
        end else begin
            late_ff <= eval_data && after_end && !beyond_latest;
        end
    end

    // too late to process: dropped, though still reported as outside
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            drop_ff <= 1'b0;
        end else begin
            drop_ff <= eval_data && beyond_latest;
        end
    end

    // one frame in flight; ready stays low until its report is gone
    assign LINK.dl_ready = state_ff == ST_IDLE;
    assign LINK.ul_valid = state_ff == ST_SEND;
    assign LINK.ul_kind = ul_kind_ff;
    assign LINK.ul_cfn = ul_cfn_ff;
    assign LINK.ul_toa = toa_ff;
    assign DATA_ACCEPT = accept_ff;
    assign DATA_LATE = late_ff;
    assign DATA_DROP = drop_ff;
    assign WIN_START = toaws_ff;
    assign WIN_END = toawe_ff;
endmodule
`default_nettype wire

// >>> verilog/toa_pkg.sv
// shared constants and types for the arrival window monitor link
package toa_pkg;
    localparam int TOA_W = 16;
    localparam int CFN_W = 8;
    localparam int TIME_W = 16;
    localparam logic [15:0] TOAWS_RST = 16'h0100;
    localparam logic [15:0] TOAWE_RST = 16'h0010;
    localparam int CLK_PERIOD_NS = 20;
    typedef enum logic [1:0] {
        FR_DATA = 2'h0,
        FR_SYNC = 2'h1
    } dl_kind_t;
    typedef enum logic [1:0] {
        UP_TIMING_ADJ = 2'h0,
        UP_SYNC_REPLY = 2'h1
    } ul_kind_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EVAL = 2'b01,
        ST_SEND = 2'b11
    } mon_state_t;
endpackage

// >>> verilog/toa_link_if.sv
// link between the controller end and the base station end
`timescale 1ns/1ps
`default_nettype none
interface toa_link_if;
    import toa_pkg::*;
    logic dl_valid;
    logic dl_ready;
    dl_kind_t dl_kind;
    logic [CFN_W-1:0] dl_cfn;
    logic ul_valid;
    logic ul_ready;
    ul_kind_t ul_kind;
    logic [CFN_W-1:0] ul_cfn;
    logic signed [TOA_W-1:0] ul_toa;
    modport bs(input dl_valid, dl_kind, dl_cfn, ul_ready, output dl_ready, ul_valid, ul_kind, ul_cfn, ul_toa);
    modport ctl(output dl_valid, dl_kind, dl_cfn, ul_ready, input dl_ready, ul_valid, ul_kind, ul_cfn, ul_toa);
endinterface
`default_nettype wire

// >>> verilog/toa_controller.sv
// controller end: sends frames and probes, picks toa for adjustment
`timescale 1ns/1ps
`default_nettype none
module toa_controller
    import toa_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST_N,
    toa_link_if.ctl LINK,
    input wire logic SEND_REQ,
    input wire logic SEND_SYNC,
    input wire logic [CFN_W-1:0] SEND_CFN,
    output logic SEND_BUSY,
    output logic REPORT_VALID,
    output logic REPORT_SYNC,
    output logic signed [TOA_W-1:0] REPORT_TOA,
    output logic PAIR_VALID,
    output logic ADJ_ADVANCE,
    output logic ADJ_DELAY,
    output logic signed [TOA_W-1:0] ADJ_TOA
);
    logic pend_ff;
    dl_kind_t kind_ff;
    logic [CFN_W-1:0] cfn_ff;
    logic have_ff;
    logic signed [TOA_W-1:0] toa1_ff;
    logic rep_ff;
    logic rep_sync_ff;
    logic signed [TOA_W-1:0] rep_toa_ff;
    logic pair_ff;
    logic adv_ff;
    logic dly_ff;
    logic signed [TOA_W-1:0] adj_ff;
    logic signed [TOA_W-1:0] t2;

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pend_ff <= 1'b0;
            kind_ff <= FR_DATA;
            cfn_ff <= '0;
        end else if (pend_ff) begin
            if (LINK.dl_ready) begin
                pend_ff <= 1'b0;
            end
        end else if (SEND_REQ) begin
            pend_ff <= 1'b1;
            kind_ff <= SEND_SYNC ? FR_SYNC : FR_DATA;
            cfn_ff <= SEND_CFN;
        end
    end

    assign LINK.dl_valid = pend_ff;
    assign LINK.dl_kind = kind_ff;
    assign LINK.dl_cfn = cfn_ff;
    assign LINK.ul_ready = 1'b1;
    assign SEND_BUSY = pend_ff;
    assign t2 = LINK.ul_toa;

    // two consecutive sync replies form a pair of legs
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            have_ff <= 1'b0;
            toa1_ff <= '0;
            rep_ff <= 1'b0;
            rep_sync_ff <= 1'b0;
            rep_toa_ff <= '0;
            pair_ff <= 1'b0;
            adv_ff <= 1'b0;
            dly_ff <= 1'b0;
            adj_ff <= '0;
        end else begin
            rep_ff <= LINK.ul_valid;
            pair_ff <= 1'b0;
            adv_ff <= 1'b0;
            dly_ff <= 1'b0;
            if (LINK.ul_valid) begin
                rep_sync_ff <= LINK.ul_kind == UP_SYNC_REPLY;
                rep_toa_ff <= LINK.ul_toa;
            end
            if (LINK.ul_valid && LINK.ul_kind == UP_SYNC_REPLY) begin
                if (!have_ff) begin
                    have_ff <= 1'b1;
                    toa1_ff <= t2;
                end else begin
                    have_ff <= 1'b0;
                    pair_ff <= 1'b1;
                    if (toa1_ff < 0 && t2 < 0) begin
                        adv_ff <= 1'b1;
                        adj_ff <= (toa1_ff < t2) ? toa1_ff : t2;
                    end else if (toa1_ff < 0 || t2 < 0) begin
                        adv_ff <= 1'b1;
                        adj_ff <= (toa1_ff < 0) ? toa1_ff : t2;
                    end else if (toa1_ff > 0 && t2 > 0) begin
                        dly_ff <= 1'b1;
                        adj_ff <= (toa1_ff < t2) ? toa1_ff : t2;
                    end
                end
            end
        end
    end

    assign REPORT_VALID = rep_ff;
    assign REPORT_SYNC = rep_sync_ff;
    assign REPORT_TOA = rep_toa_ff;
    assign PAIR_VALID = pair_ff;
    assign ADJ_ADVANCE = adv_ff;
    assign ADJ_DELAY = dly_ff;
    assign ADJ_TOA = adj_ff;
endmodule
`default_nettype wire

// >>> verification/toa_link_chk.sv
// checker on the frame link between controller and base station
`timescale 1ns/1ps
`default_nettype none
module toa_link_chk
    import toa_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic dl_valid,
    input wire logic dl_ready,
    input wire dl_kind_t dl_kind,
    input wire logic [CFN_W-1:0] dl_cfn,
    input wire logic ul_valid,
    input wire logic ul_ready,
    input wire ul_kind_t ul_kind,
    input wire logic [CFN_W-1:0] ul_cfn,
    input wire logic signed [TOA_W-1:0] ul_toa
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    wire take = dl_valid && dl_ready;
    sequence s_take_sync; take && dl_kind == FR_SYNC; endsequence
    sequence s_reply; ul_valid && ul_kind == UP_SYNC_REPLY; endsequence
    property p_sync_reply; s_take_sync |-> ##2 s_reply; endproperty
    a_sync_reply: assert property (p_sync_reply) else $error("sync reply missing");
    property p_cfn_echo; s_take_sync |-> ##2 ul_cfn == $past(dl_cfn, 2); endproperty
    a_cfn_echo: assert property (p_cfn_echo) else $error("cfn not echoed");
    property p_sync_hold; s_take_sync |=> !dl_ready [*2] ##1 dl_ready; endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("ready wrong around probe");
    property p_data_kind; take && dl_kind == FR_DATA |-> ##2 !ul_valid || ul_kind == UP_TIMING_ADJ; endproperty
    a_data_kind: assert property (p_data_kind) else $error("data frame gave wrong report");
    property p_ul_cause; $rose(ul_valid) |-> $past(take, 2); endproperty
    a_ul_cause: assert property (p_ul_cause) else $error("report without frame");
    property p_ul_one; ul_valid && ul_ready |=> !ul_valid; endproperty
    a_ul_one: assert property (p_ul_one) else $error("report repeated");
    // inside window never reports, so a timing adjustment report always has a nonzero offset
    property p_adj_nonzero; ul_valid && ul_kind == UP_TIMING_ADJ |-> ul_toa != 0; endproperty
    a_adj_nonzero: assert property (p_adj_nonzero) else $error("zero offset reported");
    property p_ready_back; take |-> ##[2:3] dl_ready; endproperty
    a_ready_back: assert property (p_ready_back) else $error("link stuck busy");
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// self-checking bench joining controller and base station ends
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin fail_count++; \
    $display("[FAIL] %s exp %h got %h", n, e, s); end end
module tb_top
    import toa_pkg::*;
;
    logic ref_clk = 0, rst_n = 0, cfg_load = 0, send_req = 0, send_sync = 0;
    logic [TIME_W-1:0] cfg_toaws = '0, cfg_toawe = '0, arrival_time = '0, w_start, w_end;
    logic [CFN_W-1:0] send_cfn = '0;
    logic d_acc, d_late, d_drop, busy, r_valid, r_sync, p_valid, a_adv, a_dly;
    logic signed [TOA_W-1:0] r_toa, a_toa, got_r, got_a;
    logic [7:0] seen;
    int fail_count = 0, checks_done = 0;
    // offsets below are against a window end of 0x10 and start of 0x40
    logic [TIME_W-1:0] d_arr[6] = '{16'h0020, 16'h0080, 16'h0008, 16'h0000, 16'h0050, 16'h0010};
    logic [3:0] d_exp[6] = '{4'b1000, 4'b0001, 4'b1101, 4'b0011, 4'b1000, 4'b1000};
    logic [3:0] d_msk[6] = '{4'b1111, 4'b0111, 4'b1111, 4'b1111, 4'b1111, 4'b1111};
    logic [TIME_W-1:0] s_arr[8] = '{16'h0020, 16'h0018, 16'h000c, 16'h0008, 16'h000c, 16'h0030, 16'h0030, 16'h000c};
    logic [1:0] s_act[4] = '{2'b01, 2'b10, 2'b10, 2'b10};
    logic [TOA_W-1:0] s_adj[4] = '{16'h0008, 16'hfff8, 16'hfffc, 16'hfffc};
    toa_link_if link();
    toa_base_station toa_base_station_inst(.REF_CLK(ref_clk), .RST_N(rst_n), .LINK(link), .CFG_LOAD(cfg_load),
        .CFG_TOAWS(cfg_toaws), .CFG_TOAWE(cfg_toawe), .ARRIVAL_TIME(arrival_time), .DATA_ACCEPT(d_acc),
        .DATA_LATE(d_late), .DATA_DROP(d_drop), .WIN_START(w_start), .WIN_END(w_end));
    toa_controller toa_controller_inst(.REF_CLK(ref_clk), .RST_N(rst_n), .LINK(link), .SEND_REQ(send_req),
        .SEND_SYNC(send_sync), .SEND_CFN(send_cfn), .SEND_BUSY(busy), .REPORT_VALID(r_valid),
        .REPORT_SYNC(r_sync), .REPORT_TOA(r_toa), .PAIR_VALID(p_valid), .ADJ_ADVANCE(a_adv),
        .ADJ_DELAY(a_dly), .ADJ_TOA(a_toa));
    toa_link_chk toa_link_chk_inst(.REF_CLK(ref_clk), .RST_N(rst_n), .dl_valid(link.dl_valid),
        .dl_ready(link.dl_ready), .dl_kind(link.dl_kind), .dl_cfn(link.dl_cfn), .ul_valid(link.ul_valid),
        .ul_ready(link.ul_ready), .ul_kind(link.ul_kind), .ul_cfn(link.ul_cfn), .ul_toa(link.ul_toa));
    initial forever #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
    task automatic summarize();
        if (fail_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // sticky capture of every pulse over a fixed span, enough for one frame
    task automatic xfer(input logic sync, input logic [TIME_W-1:0] arr);
        send_sync = sync;
        arrival_time = arr;
        send_cfn = send_cfn + 8'h01;
        send_req = 1;
        seen = '0;
        got_r = 'x;
        got_a = 'x;
        @(negedge ref_clk) send_req = 0;
        `CHK("send_busy", 1'b1, busy)
        repeat (10) begin
            seen |= {d_acc, d_late, d_drop, r_valid, r_valid & r_sync, p_valid, a_adv, a_dly};
            if (r_valid) got_r = r_toa;
            if (a_adv | a_dly) got_a = a_toa;
            @(negedge ref_clk);
        end
        `CHK("send_busy", 1'b0, busy)
    endtask
    initial begin
        repeat (12) @(negedge ref_clk);
        rst_n = 1;
        `CHK("win_start", TOAWS_RST, w_start)
        `CHK("win_end", TOAWE_RST, w_end)
        cfg_toaws = 16'h0040;
        cfg_toawe = 16'h0010;
        cfg_load = 1;
        @(negedge ref_clk) cfg_load = 0;
        @(negedge ref_clk);
        `CHK("win_start", 16'h0040, w_start)
        `CHK("win_end", 16'h0010, w_end)
        foreach (d_arr[i]) begin
            xfer(0, d_arr[i]);
            `CHK("data_flags", d_exp[i], seen[7:4] & d_msk[i])
            if (d_exp[i][0]) `CHK("data_toa", d_arr[i] - 16'h0010, got_r)
        end
        foreach (s_arr[i]) begin
            xfer(1, s_arr[i]);
            `CHK("sync_reply", 2'b11, seen[4:3])
            `CHK("sync_toa", s_arr[i] - 16'h0010, got_r)
            `CHK("pair", {i[0], s_act[i / 2] & {2{i[0]}}}, seen[2:0])
            if (i[0]) `CHK("adj_toa", s_adj[i / 2], got_a)
        end
        summarize();
    end
    initial begin
        #20us;
        fail_count++;
        summarize();
    end
endmodule
`default_nettype wire
